// file: verilog/lmds_unit.sv
// arithmetic unit end: long multiply, divide, saturate, sticky flag
// assumes the issuer keeps its own operand limits; one clock, async reset
//
// Functional notes
// - full product, low and high words out
// - unsigned multiplies take operands unsigned
// - signed multiplies take operands signed
// - unsigned accumulate adds product to pair
// - signed accumulate adds product to pair
// - issuer never repeats one destination twice
// - issuer never names stack pointer, counter, except in status commands
// - multiply leaves flags alone, saturate only sets sticky
// - signed divide writes quotient
// - unsigned divide writes quotient
// - quotient truncates toward zero
// - divide leaves all flags unchanged
// - signed saturation clamps to n-bit range
// - unsigned saturation clamps to zero..max
// - saturation sets the sticky flag
// - only status write clears sticky flag
// - flag visible only through status read
// - width 1..32 signed, 0..31 unsigned
// - shift applied before clamping
// - right shift 1..31 or left 0..31
`timescale 1ns/100ps
module lmds_unit
(
	lmds_if.dev bus
);
	localparam int W  = lmds_pkg::DATA_W;
	localparam int WW = lmds_pkg::WIDE_W;

	lmds_pkg::lmds_state_e       state_r;     // sequencer state
	lmds_pkg::lmds_state_e       state_nxt;   // next sequencer state
	logic                        q_r;         // sticky saturation flag
	logic                        q_nxt;       // its next value
	logic                        ready_r;     // request ready
	logic                        ready_nxt;
	logic                        vld_r;       // result pulse
	logic                        vld_nxt;
	logic                        pair_r;      // pair written
	logic                        pair_nxt;
	logic [W-1:0]                lo_r;        // low result
	logic [W-1:0]                lo_nxt;
	logic [W-1:0]                hi_r;        // high result
	logic [W-1:0]                hi_nxt;
	logic [lmds_pkg::REG_W-1:0]  dlo_r;       // low destination
	logic [lmds_pkg::REG_W-1:0]  dhi_r;       // high destination
	logic [W:0]                  rem_r;       // partial remainder
	logic [W:0]                  rem_nxt;
	logic [W-1:0]                quo_r;       // dividend / quotient shifter
	logic [W-1:0]                quo_nxt;
	logic [W-1:0]                dvs_r;       // divisor magnitude
	logic                        neg_r;       // quotient to be negated
	logic [lmds_pkg::CNT_W-1:0]  cnt_r;       // divide steps left
	logic [lmds_pkg::CNT_W-1:0]  cnt_nxt;

	// request decode
	wire take    = bus.req_valid & ready_r;
	wire is_smul = (bus.req_op == lmds_pkg::LMDS_MULS) |
	               (bus.req_op == lmds_pkg::LMDS_MACS);
	wire is_acc  = (bus.req_op == lmds_pkg::LMDS_MACU) |
	               (bus.req_op == lmds_pkg::LMDS_MACS);
	wire is_mul  = is_smul | is_acc | (bus.req_op == lmds_pkg::LMDS_MULU);
	wire is_divs = bus.req_op == lmds_pkg::LMDS_DIVS;
	wire is_div  = is_divs | (bus.req_op == lmds_pkg::LMDS_DIVU);
	wire is_sats = bus.req_op == lmds_pkg::LMDS_SATS;
	wire is_sat  = is_sats | (bus.req_op == lmds_pkg::LMDS_SATU);

	// operands widened by sign or zero, so one multiplier serves both
	wire [WW-1:0] ext_a = {{W{is_smul & bus.req_a[W-1]}}, bus.req_a};
	wire [WW-1:0] ext_b = {{W{is_smul & bus.req_b[W-1]}}, bus.req_b};
	// low 64 bits of the product are exact in either signedness
	wire [WW-1:0] prod  = ext_a * ext_b;
	// sum modulo 2^64 is the same for signed and unsigned pairs
	wire [WW-1:0] acc   = prod + {bus.req_hi, bus.req_lo};
	wire [WW-1:0] mres  = is_acc ? acc : prod;

	// pre-shift ahead of the clamp
	wire [W-1:0] shv = bus.req_sra
	                 ? W'($signed(bus.req_a) >>> bus.req_shamt)
	                 : W'(bus.req_a << bus.req_shamt);
	wire signed [W:0] sx = $signed({shv[W-1], shv});
	// limits in 33 bits so n=32 and n=0 do not overflow
	wire [W:0] one   = {{W{1'b0}}, 1'b1};
	wire [W:0] nm1   = one << (bus.req_width - 6'h01);
	wire [W:0] nfull = one << bus.req_width;
	wire signed [W:0] smax = $signed(nm1 - one);
	wire signed [W:0] smin = -$signed(nm1);
	wire signed [W:0] umax = $signed(nfull - one);
	wire [W-1:0] clps = (sx < smin) ? smin[W-1:0]
	                  : (sx > smax) ? smax[W-1:0] : shv;
	wire [W-1:0] clpu = (sx < 0) ? {W{1'b0}}
	                  : (sx > umax) ? umax[W-1:0] : shv;
	wire [W-1:0] sres = is_sats ? clps : clpu;
	wire         hit  = sres != shv;

	// divider set-up: magnitudes, sign of quotient
	wire         na   = is_divs & bus.req_a[W-1];
	wire         nb   = is_divs & bus.req_b[W-1];
	wire [W-1:0] mag_a = na ? W'(-bus.req_a) : bus.req_a;
	wire [W-1:0] mag_b = nb ? W'(-bus.req_b) : bus.req_b;
	wire         dz   = bus.req_b == {W{1'b0}};

	// one restoring step: shift in next dividend bit, try subtract
	wire [W:0]   sh   = {rem_r[W-1:0], quo_r[W-1]};
	wire [W:0]   trl  = sh - {1'b0, dvs_r};
	wire         fit  = ~trl[W];
	// magnitude quotient truncates; negating it rounds toward zero
	wire [W-1:0] qfin = neg_r ? W'(-quo_r) : quo_r;

	// next-state and result selection
	always_comb
	begin
		state_nxt = state_r;
		q_nxt     = q_r;
		ready_nxt = ready_r;
		vld_nxt   = 1'b0;
		pair_nxt  = pair_r;
		lo_nxt    = lo_r;
		hi_nxt    = hi_r;
		rem_nxt   = rem_r;
		quo_nxt   = quo_r;
		cnt_nxt   = cnt_r;
		case (state_r)
			lmds_pkg::LMDS_IDLE:
			begin
				if (take & is_mul)
				begin
					// flags untouched by multiplies
					vld_nxt  = 1'b1;
					pair_nxt = 1'b1;
					lo_nxt   = mres[W-1:0];
					hi_nxt   = mres[WW-1:W];
				end
				else if (take & is_sat)
				begin
					vld_nxt  = 1'b1;
					pair_nxt = 1'b0;
					lo_nxt   = sres;
					// set only, never cleared by arithmetic
					q_nxt    = q_r | hit;
				end
				else if (take & is_div & dz)
				begin
					// zero divisor: zero quotient, no flag
					vld_nxt  = 1'b1;
					pair_nxt = 1'b0;
					lo_nxt   = {W{1'b0}};
				end
				else if (take & is_div)
				begin
					state_nxt = lmds_pkg::LMDS_DIVIDE;
					ready_nxt = 1'b0;
					rem_nxt   = {(W+1){1'b0}};
					quo_nxt   = mag_a;
					cnt_nxt   = lmds_pkg::CNT_W'(lmds_pkg::DIV_STEPS);
				end
				else if (take & (bus.req_op == lmds_pkg::LMDS_QWRITE))
				begin
					// explicit status write is the only clear
					q_nxt = bus.req_a[lmds_pkg::QBIT];
				end
				else if (take & (bus.req_op == lmds_pkg::LMDS_QREAD))
				begin
					// the one place the flag leaves the unit
					vld_nxt  = 1'b1;
					pair_nxt = 1'b0;
					lo_nxt   = W'({q_r, {lmds_pkg::QBIT{1'b0}}});
				end
			end
			lmds_pkg::LMDS_DIVIDE:
			begin
				if (cnt_r == {lmds_pkg::CNT_W{1'b0}})
				begin
					// flags stay as they were
					state_nxt = lmds_pkg::LMDS_IDLE;
					ready_nxt = 1'b1;
					vld_nxt   = 1'b1;
					pair_nxt  = 1'b0;
					lo_nxt    = qfin;
				end
				else
				begin
					rem_nxt = fit ? trl : sh;
					quo_nxt = {quo_r[W-2:0], fit};
					cnt_nxt = cnt_r - 6'h01;
				end
			end
			default:
			begin
				state_nxt = lmds_pkg::LMDS_IDLE;
				ready_nxt = 1'b1;
			end
		endcase
	end

	// control state and result registers
	always_ff @(posedge bus.ref_clk or posedge bus.rst)
	begin
		if (bus.rst)
		begin
			state_r <= lmds_pkg::LMDS_IDLE;
			q_r     <= lmds_pkg::Q_RST;
			ready_r <= 1'b1;
			vld_r   <= 1'b0;
			pair_r  <= 1'b0;
			lo_r    <= {W{1'b0}};
			hi_r    <= {W{1'b0}};
			cnt_r   <= {lmds_pkg::CNT_W{1'b0}};
		end
		else
		begin
			state_r <= state_nxt;
			q_r     <= q_nxt;
			ready_r <= ready_nxt;
			vld_r   <= vld_nxt;
			pair_r  <= pair_nxt;
			lo_r    <= lo_nxt;
			hi_r    <= hi_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// divider datapath stepped each cycle; divisor, sign and destinations loaded on a take
	always_ff @(posedge bus.ref_clk or posedge bus.rst)
	begin
		if (bus.rst)
		begin
			rem_r <= {(W+1){1'b0}};
			quo_r <= {W{1'b0}};
			dvs_r <= {W{1'b0}};
			neg_r <= 1'b0;
			dlo_r <= {lmds_pkg::REG_W{1'b0}};
			dhi_r <= {lmds_pkg::REG_W{1'b0}};
		end
		else
		begin
			rem_r <= rem_nxt;
			quo_r <= quo_nxt;
			if (take)
			begin
				dvs_r <= mag_b;
				neg_r <= na ^ nb;
				// destinations trusted distinct and not sp/pc
				dlo_r <= bus.req_dst_lo;
				dhi_r <= bus.req_dst_hi;
			end
		end
	end

	assign bus.req_ready  = ready_r;
	assign bus.rsp_valid  = vld_r;
	assign bus.rsp_pair   = pair_r;
	assign bus.rsp_lo     = lo_r;
	assign bus.rsp_hi     = hi_r;
	assign bus.rsp_dst_lo = dlo_r;
	assign bus.rsp_dst_hi = dhi_r;
endmodule

// file: verilog/lmds_pkg.sv
// package for the long multiply, divide and saturate unit
// assumes both ends and the bench refer to it as lmds_pkg::name
package lmds_pkg;
	localparam int DATA_W    = 32; // operand width
	localparam int WIDE_W    = 64; // product and accumulator width
	localparam int WIDTH_W   = 6;  // saturation width field
	localparam int SHAMT_W   = 5;  // pre-shift amount field
	localparam int REG_W     = 4;  // register index width
	localparam int CNT_W     = 6;  // divide step counter width
	localparam int QBIT      = 27; // sticky flag position in status word
	localparam int SATS_MIN  = 1;  // least signed saturation width
	localparam int SATS_MAX  = 32; // largest signed saturation width
	localparam int SATU_MAX  = 31; // largest unsigned saturation width
	localparam int SRA_MIN   = 1;  // least arithmetic right shift
	localparam int DIV_STEPS = 32; // one quotient bit per cycle
	localparam logic [REG_W-1:0] SP_IDX = 4'hD; // stack pointer index
	localparam logic [REG_W-1:0] PC_IDX = 4'hF; // program counter index
	localparam logic Q_RST = 1'h0; // sticky flag after reset

	// operations the unit accepts
	typedef enum logic [3:0] {
		LMDS_MULU,
		LMDS_MACU,
		LMDS_MULS,
		LMDS_MACS,
		LMDS_DIVS,
		LMDS_DIVU,
		LMDS_SATS,
		LMDS_SATU,
		LMDS_QWRITE,
		LMDS_QREAD
	} lmds_op_e;

	// device sequencer states
	typedef enum logic {
		LMDS_IDLE,
		LMDS_DIVIDE
	} lmds_state_e;
endpackage

// file: verilog/lmds_if.sv
// interface joining the issuing logic and the arithmetic unit
// assumes one clock and one async active-high reset for both ends
`timescale 1ns/100ps
interface lmds_if
(
	input wire logic ref_clk,
	input wire logic rst
);
	logic                             req_valid;   // request offered
	logic                             req_ready;   // unit can take it
	lmds_pkg::lmds_op_e               req_op;      // operation
	logic [lmds_pkg::DATA_W-1:0]      req_a;       // first source operand
	logic [lmds_pkg::DATA_W-1:0]      req_b;       // second source operand
	logic [lmds_pkg::DATA_W-1:0]      req_hi;      // accumulator high word
	logic [lmds_pkg::DATA_W-1:0]      req_lo;      // accumulator low word
	logic [lmds_pkg::WIDTH_W-1:0]     req_width;   // saturation width
	logic                             req_sra;     // 1 shift right, 0 left
	logic [lmds_pkg::SHAMT_W-1:0]     req_shamt;   // pre-shift amount
	logic [lmds_pkg::REG_W-1:0]       req_dst_lo;  // low destination
	logic [lmds_pkg::REG_W-1:0]       req_dst_hi;  // high destination
	logic                             rsp_valid;   // result pulse
	logic                             rsp_pair;    // both words written
	logic [lmds_pkg::DATA_W-1:0]      rsp_lo;      // low / single result
	logic [lmds_pkg::DATA_W-1:0]      rsp_hi;      // high result
	logic [lmds_pkg::REG_W-1:0]       rsp_dst_lo;  // low destination
	logic [lmds_pkg::REG_W-1:0]       rsp_dst_hi;  // high destination

	modport dev
	(
		input  ref_clk, rst, req_valid, req_op, req_a, req_b, req_hi, req_lo,
		input  req_width, req_sra, req_shamt, req_dst_lo, req_dst_hi,
		output req_ready, rsp_valid, rsp_pair, rsp_lo, rsp_hi,
		output rsp_dst_lo, rsp_dst_hi
	);
	modport iss
	(
		input  ref_clk, rst, req_ready, rsp_valid, rsp_pair, rsp_lo, rsp_hi,
		input  rsp_dst_lo, rsp_dst_hi,
		output req_valid, req_op, req_a, req_b, req_hi, req_lo,
		output req_width, req_sra, req_shamt, req_dst_lo, req_dst_hi
	);
endinterface

// file: verilog/lmds_issue.sv
// issuing end: screens commands, offers them to the unit, returns results
// assumes the user holds cmd_* steady while cmd_valid and cmd_ready meet
`timescale 1ns/100ps
module lmds_issue
(
	lmds_if.iss                         bus,
	input  wire logic                   cmd_valid,
	output logic                        cmd_ready,
	input  wire lmds_pkg::lmds_op_e     cmd_op,
	input  wire logic [31:0]            cmd_a,
	input  wire logic [31:0]            cmd_b,
	input  wire logic [31:0]            cmd_hi,
	input  wire logic [31:0]            cmd_lo,
	input  wire logic [5:0]             cmd_width,
	input  wire logic                   cmd_sra,
	input  wire logic [4:0]             cmd_shamt,
	input  wire logic [3:0]             cmd_dst_lo,
	input  wire logic [3:0]             cmd_dst_hi,
	input  wire logic [3:0]             cmd_src_a,
	input  wire logic [3:0]             cmd_src_b,
	output logic                        cmd_error,
	output logic                        out_valid,
	output logic                        out_pair,
	output logic [31:0]                 out_lo,
	output logic [31:0]                 out_hi,
	output logic [3:0]                  out_dst_lo,
	output logic [3:0]                  out_dst_hi
);
	logic req_valid_r; // offer pending
	logic rdy_r;       // user-side ready
	logic err_r;       // refusal pulse

	// register indices that may not appear
	function automatic logic bad_idx(input logic [3:0] i);
		bad_idx = (i == lmds_pkg::SP_IDX) | (i == lmds_pkg::PC_IDX);
	endfunction

	wire is_pair = (cmd_op == lmds_pkg::LMDS_MULU) |
	               (cmd_op == lmds_pkg::LMDS_MACU) |
	               (cmd_op == lmds_pkg::LMDS_MULS) |
	               (cmd_op == lmds_pkg::LMDS_MACS);
	wire is_sats = cmd_op == lmds_pkg::LMDS_SATS;
	wire is_satu = cmd_op == lmds_pkg::LMDS_SATU;
	wire is_ctl  = (cmd_op == lmds_pkg::LMDS_QWRITE) |
	               (cmd_op == lmds_pkg::LMDS_QREAD);
	// same register twice as pair destination
	wire bad_pair = is_pair & (cmd_dst_lo == cmd_dst_hi);
	// stack pointer or program counter in any used register, except status commands
	wire bad_reg  = ~is_ctl & (bad_idx(cmd_src_a) | bad_idx(cmd_src_b) |
	                bad_idx(cmd_dst_lo) |
	                (is_pair & bad_idx(cmd_dst_hi)));
	wire bad_w    = (is_sats & ((cmd_width < 6'(lmds_pkg::SATS_MIN)) |
	                (cmd_width > 6'(lmds_pkg::SATS_MAX)))) |
	                (is_satu & (cmd_width > 6'(lmds_pkg::SATU_MAX)));
	wire bad_sh   = (is_sats | is_satu) & cmd_sra &
	                (cmd_shamt < 5'(lmds_pkg::SRA_MIN));
	wire bad      = bad_pair | bad_reg | bad_w | bad_sh;
	wire accept   = cmd_valid & rdy_r;
	wire handed   = req_valid_r & bus.req_ready;
	wire vld_nxt  = (req_valid_r & ~handed) | (accept & ~bad);

	// offer holding register; one command in flight toward the unit
	always_ff @(posedge bus.ref_clk or posedge bus.rst)
	begin
		if (bus.rst)
		begin
			req_valid_r <= 1'b0;
			rdy_r       <= 1'b1;
			err_r       <= 1'b0;
		end
		else
		begin
			req_valid_r <= vld_nxt;
			rdy_r       <= ~vld_nxt;
			err_r       <= accept & bad;
		end
	end

	// command capture, only for a legal accepted command
	always_ff @(posedge bus.ref_clk or posedge bus.rst)
	begin
		if (bus.rst)
		begin
			bus.req_op     <= lmds_pkg::LMDS_MULU;
			bus.req_a      <= 32'h0;
			bus.req_b      <= 32'h0;
			bus.req_hi     <= 32'h0;
			bus.req_lo     <= 32'h0;
			bus.req_width  <= 6'h0;
			bus.req_sra    <= 1'b0;
			bus.req_shamt  <= 5'h0;
			bus.req_dst_lo <= 4'h0;
			bus.req_dst_hi <= 4'h0;
		end
		else if (accept & ~bad)
		begin
			bus.req_op     <= cmd_op;
			bus.req_a      <= cmd_a;
			bus.req_b      <= cmd_b;
			bus.req_hi     <= cmd_hi;
			bus.req_lo     <= cmd_lo;
			bus.req_width  <= cmd_width;
			bus.req_sra    <= cmd_sra;
			bus.req_shamt  <= cmd_shamt;
			bus.req_dst_lo <= cmd_dst_lo;
			bus.req_dst_hi <= cmd_dst_hi;
		end
	end

	// results registered once more toward the user
	always_ff @(posedge bus.ref_clk or posedge bus.rst)
	begin
		if (bus.rst)
		begin
			out_valid  <= 1'b0;
			out_pair   <= 1'b0;
			out_lo     <= 32'h0;
			out_hi     <= 32'h0;
			out_dst_lo <= 4'h0;
			out_dst_hi <= 4'h0;
		end
		else
		begin
			out_valid  <= bus.rsp_valid;
			out_pair   <= bus.rsp_pair;
			out_lo     <= bus.rsp_lo;
			out_hi     <= bus.rsp_hi;
			out_dst_lo <= bus.rsp_dst_lo;
			out_dst_hi <= bus.rsp_dst_hi;
		end
	end

	assign bus.req_valid = req_valid_r;
	assign cmd_ready     = rdy_r;
	assign cmd_error     = err_r;
endmodule

// file: verif/lmds_properties.sv
// checker on the link between issuer and arithmetic unit
// assumes the bench wires the interface signals to it by name
`timescale 1ns/100ps
module lmds_properties
(
	input wire logic                         ref_clk,
	input wire logic                         rst,
	input wire logic                         req_valid,
	input wire logic                         req_ready,
	input wire lmds_pkg::lmds_op_e           req_op,
	input wire logic [lmds_pkg::DATA_W-1:0]  req_a,
	input wire logic [lmds_pkg::DATA_W-1:0]  req_b,
	input wire logic [lmds_pkg::DATA_W-1:0]  req_hi,
	input wire logic [lmds_pkg::DATA_W-1:0]  req_lo,
	input wire logic [lmds_pkg::WIDTH_W-1:0] req_width,
	input wire logic                         req_sra,
	input wire logic [lmds_pkg::SHAMT_W-1:0] req_shamt,
	input wire logic                         rsp_valid,
	input wire logic                         rsp_pair,
	input wire logic [lmds_pkg::DATA_W-1:0]  rsp_lo,
	input wire logic [lmds_pkg::DATA_W-1:0]  rsp_hi
);
	logic        take;    // request handed over
	logic        sat_op;  // either saturation
	logic [31:0] shifted; // operand after the pre-shift
	logic        q_r;     // expected sticky flag
	logic        q_nxt;   // its next value

	// pre-shift; kept apart so the right shift stays signed
	function automatic logic [31:0] shift_f(input logic [31:0] a,
		input logic sra, input logic [4:0] sh);
		logic signed [31:0] s;
		s = a;
		if (sra)
			return s >>> sh;
		return a << sh;
	endfunction

	// clamp in 64 bits so width 32 cannot wrap
	function automatic logic [31:0] sat_f(input logic sgn,
		input logic [31:0] v, input logic [5:0] n);
		longint x;
		longint mx;
		longint mn;
		x = longint'(signed'(v));
		mx = sgn ? (longint'(1) << (n - 1)) - 1 : (longint'(1) << n) - 1;
		mn = sgn ? -(longint'(1) << (n - 1)) : 0;
		if (x > mx)
			x = mx;
		else if (x < mn)
			x = mn;
		return x[31:0];
	endfunction

	assign take = req_valid && req_ready;
	assign sat_op = req_op == lmds_pkg::LMDS_SATS ||
		req_op == lmds_pkg::LMDS_SATU;
	assign shifted = shift_f(req_a, req_sra, req_shamt);
	// flag model: status write loads it, a clamp sets it
	assign q_nxt = (take && req_op == lmds_pkg::LMDS_QWRITE) ?
		req_a[lmds_pkg::QBIT] : q_r | (take && sat_op &&
		sat_f(req_op == lmds_pkg::LMDS_SATS, shifted, req_width) != shifted);

	// flag register of the model
	always_ff @(posedge ref_clk or posedge rst)
		if (rst)
			q_r <= lmds_pkg::Q_RST;
		else
			q_r <= q_nxt;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	unsigned_product_a: assert property (
		take && req_op == lmds_pkg::LMDS_MULU |=> rsp_valid && rsp_pair &&
		{rsp_hi, rsp_lo} == 64'($past(req_a)) * 64'($past(req_b)))
		else $error("unsigned long product wrong");
	signed_product_a: assert property (
		take && req_op == lmds_pkg::LMDS_MULS |=> rsp_valid && rsp_pair &&
		{rsp_hi, rsp_lo} == 64'(signed'($past(req_a))) *
		64'(signed'($past(req_b))))
		else $error("signed long product wrong");
	unsigned_accum_a: assert property (
		take && req_op == lmds_pkg::LMDS_MACU |=> rsp_valid && rsp_pair &&
		{rsp_hi, rsp_lo} == 64'($past(req_a)) * 64'($past(req_b)) +
		{$past(req_hi), $past(req_lo)})
		else $error("unsigned accumulate wrong");
	signed_accum_a: assert property (
		take && req_op == lmds_pkg::LMDS_MACS |=> rsp_valid && rsp_pair &&
		{rsp_hi, rsp_lo} == 64'(signed'($past(req_a))) *
		64'(signed'($past(req_b))) + {$past(req_hi), $past(req_lo)})
		else $error("signed accumulate wrong");
	unsigned_quot_a: assert property (
		take && req_op == lmds_pkg::LMDS_DIVU && req_b != 0 |=>
		!req_ready [*8] ##26 rsp_valid && !rsp_pair &&
		rsp_lo == $past(req_a, 34) / $past(req_b, 34))
		else $error("unsigned quotient wrong or late");
	signed_quot_a: assert property (
		take && req_op == lmds_pkg::LMDS_DIVS && req_b != 0 |=>
		!req_ready [*8] ##26 rsp_valid && !rsp_pair && rsp_lo ==
		32'(signed'($past(req_a, 34)) / signed'($past(req_b, 34))))
		else $error("signed quotient wrong or late");
	zero_divisor_a: assert property (
		take && req_b == 0 && (req_op == lmds_pkg::LMDS_DIVS ||
		req_op == lmds_pkg::LMDS_DIVU) |=> rsp_valid && rsp_lo == 0)
		else $error("zero divisor result wrong");
	clamp_result_a: assert property (
		take && sat_op |=> rsp_valid && !rsp_pair && rsp_lo == sat_f(
		$past(req_op) == lmds_pkg::LMDS_SATS, $past(shifted),
		$past(req_width)))
		else $error("saturation result wrong");
	flag_read_a: assert property (
		take && req_op == lmds_pkg::LMDS_QREAD |=>
		rsp_valid && rsp_lo == 32'($past(q_r)) << lmds_pkg::QBIT)
		else $error("sticky flag read wrong");

	cover property (take && req_op == lmds_pkg::LMDS_MACS);
	cover property (take && req_op == lmds_pkg::LMDS_DIVS ##34 rsp_valid);
	cover property (q_r && take && req_op == lmds_pkg::LMDS_QREAD);
endmodule

// file: verif/testbench.sv
// self-checking bench: issuer and unit joined back to back
// assumes the package, interface, both ends and checker compiled first
`timescale 1ns/100ps
module testbench;
	localparam time PERIOD = 50ns; // 20 MHz
	localparam time SKEW   = 5ns;  // inputs move this long after the edge

	// one case: command beside its result; op is the enum ordinal
	typedef struct packed
	{
		logic [3:0]  op;  // operation ordinal
		logic [31:0] a;   // first source operand
		logic [31:0] b;   // second source operand
		logic [63:0] acc; // accumulator, high word on top
		logic [11:0] ctl; // {width, sra, shamt}
		logic [63:0] res; // expected pair or single word
	} lmds_row_s;

	logic               ref_clk, rst, cmd_valid, cmd_ready, cmd_sra;
	logic               cmd_error, out_valid, out_pair;
	lmds_pkg::lmds_op_e cmd_op;
	logic [31:0]        cmd_a, cmd_b, cmd_hi, cmd_lo, out_lo, out_hi;
	logic [5:0]         cmd_width;
	logic [4:0]         cmd_shamt;
	logic [3:0]         cmd_dst_lo, cmd_dst_hi, cmd_src_a, cmd_src_b;
	logic [3:0]         out_dst_lo, out_dst_hi;
	int                 num_errors, comparisons;
	lmds_row_s          r;   // scratch case for hand tests
	lmds_row_s          rows [21] = '{
		'{4'h0, '1, '1, 64'h0, 12'h0, 64'hFFFFFFFE00000001},
		'{4'h2, '1, '1, 64'h0, 12'h0, 64'h1},
		'{4'h2, 32'h80000000, 32'h2, 64'h0, 12'h0, 64'hFFFFFFFF00000000},
		'{4'h1, '1, 32'h2, 64'h2, 12'h0, 64'h200000000},
		'{4'h3, '1, 32'h3, 64'h5, 12'h0, 64'h2},
		'{4'h3, 32'h2, 32'h3, -64'sd16, 12'h0, -64'sd10},
		'{4'h5, 32'h7, 32'h2, 64'h0, 12'h0, 64'h3},
		'{4'h5, '1, 32'h10, 64'h0, 12'h0, 64'hFFFFFFF},
		'{4'h4, 32'hFFFFFFF9, 32'h2, 64'h0, 12'h0, 64'hFFFFFFFD},
		'{4'h4, 32'h7, 32'hFFFFFFFE, 64'h0, 12'h0, 64'hFFFFFFFD},
		'{4'h5, 32'h5, 32'h0, 64'h0, 12'h0, 64'h0},
		'{4'h4, 32'h5, 32'h0, 64'h0, 12'h0, 64'h0},
		'{4'h6, 32'h100, 32'h0, 64'h0, 12'h200, 64'h7F},
		'{4'h6, 32'hFFFFFF00, 32'h0, 64'h0, 12'h200, 64'hFFFFFF80},
		'{4'h6, 32'h80000000, 32'h0, 64'h0, 12'h800, 64'h80000000},
		'{4'h7, '1, 32'h0, 64'h0, 12'h200, 64'h0},
		'{4'h7, 32'h300, 32'h0, 64'h0, 12'h200, 64'hFF},
		'{4'h7, 32'h1, 32'h0, 64'h0, 12'h000, 64'h0},
		'{4'h6, 32'hFFF, 32'h0, 64'h0, 12'h404, 64'h7FFF},
		'{4'h6, 32'h700, 32'h0, 64'h0, 12'h224, 64'h70},
		'{4'h7, 32'h80000000, 32'h0, 64'h0, 12'h7FF, 64'h0}
	};

	lmds_if u_lmds_if (.ref_clk(ref_clk), .rst(rst));
	lmds_unit u_lmds_unit (.bus(u_lmds_if.dev));
	lmds_issue u_lmds_issue
	(
		.bus(u_lmds_if.iss), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_op(cmd_op), .cmd_a(cmd_a), .cmd_b(cmd_b), .cmd_hi(cmd_hi),
		.cmd_lo(cmd_lo), .cmd_width(cmd_width), .cmd_sra(cmd_sra),
		.cmd_shamt(cmd_shamt), .cmd_dst_lo(cmd_dst_lo),
		.cmd_dst_hi(cmd_dst_hi), .cmd_src_a(cmd_src_a),
		.cmd_src_b(cmd_src_b), .cmd_error(cmd_error),
		.out_valid(out_valid), .out_pair(out_pair), .out_lo(out_lo),
		.out_hi(out_hi), .out_dst_lo(out_dst_lo), .out_dst_hi(out_dst_hi)
	);
	lmds_properties u_lmds_properties
	(
		.ref_clk(ref_clk), .rst(rst), .req_valid(u_lmds_if.req_valid),
		.req_ready(u_lmds_if.req_ready), .req_op(u_lmds_if.req_op),
		.req_a(u_lmds_if.req_a), .req_b(u_lmds_if.req_b),
		.req_hi(u_lmds_if.req_hi), .req_lo(u_lmds_if.req_lo),
		.req_width(u_lmds_if.req_width), .req_sra(u_lmds_if.req_sra),
		.req_shamt(u_lmds_if.req_shamt), .rsp_valid(u_lmds_if.rsp_valid),
		.rsp_pair(u_lmds_if.rsp_pair), .rsp_lo(u_lmds_if.rsp_lo),
		.rsp_hi(u_lmds_if.rsp_hi)
	);

	// free-running reference clock
	always #(PERIOD / 2) ref_clk = ~ref_clk;

	// compare one value; four-state so x never matches
	task automatic check(input string name, input logic [63:0] seen,
		input logic [63:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	// counts, verdict, end of run
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// offer one command, hold it to hand-off, then await its answer
	task automatic send(input lmds_row_s c, input logic [3:0] src,
		input logic [3:0] dlo, input logic [3:0] dhi, input logic err);
		int n;
		// an edge between two offers
		@(posedge ref_clk);
		#SKEW;
		cmd_op = lmds_pkg::lmds_op_e'(c.op);
		{cmd_a, cmd_b, cmd_hi, cmd_lo} = {c.a, c.b, c.acc};
		{cmd_width, cmd_sra, cmd_shamt} = c.ctl;
		{cmd_src_a, cmd_src_b, cmd_dst_lo, cmd_dst_hi} = {src, src, dlo, dhi};
		cmd_valid = 1'b1;
		n = 0;
		// ready is a flop, so its value now holds to the next edge
		while (cmd_ready !== 1'b1 && n < 100)
		begin
			@(posedge ref_clk);
			#SKEW;
			n++;
		end
		@(posedge ref_clk);
		#SKEW;
		cmd_valid = 1'b0;
		n = 0;
		// divide answers take about 37 cycles; a status write none
		while (out_valid !== 1'b1 && cmd_error !== 1'b1 && n < 45)
		begin
			@(posedge ref_clk);
			#SKEW;
			n++;
		end
		check("cmd_error", cmd_error, err);
		check("out_valid", out_valid, !err && c.op != 4'h8);
		if (out_valid === 1'b1)
		begin
			check("out_pair", out_pair, c.op < 4'h4);
			check("out_lo", out_lo, c.res[31:0]);
			check("out_dst_lo", out_dst_lo, dlo);
			if (c.op < 4'h4)
			begin
				check("out_hi", out_hi, c.res[63:32]);
				check("out_dst_hi", out_dst_hi, dhi);
			end
		end
	endtask

	// watchdog: about thirteen times the expected run
	initial
	begin
		#(PERIOD * 5000);
		num_errors++;
		finish_test();
	end

	// main sequence
	initial
	begin
		{ref_clk, rst, cmd_valid} = 3'h2;
		r = '0;
		send_init: {cmd_op, cmd_a, cmd_b, cmd_hi, cmd_lo} = '0;
		{cmd_width, cmd_sra, cmd_shamt} = '0;
		{cmd_src_a, cmd_src_b, cmd_dst_lo, cmd_dst_hi} = '0;
		repeat (5) @(posedge ref_clk);
		#SKEW;
		check("cmd_ready", cmd_ready, 1'b1);
		check("out_valid", out_valid, 1'b0);
		rst = 1'b0;
		@(posedge ref_clk);
		#SKEW;
		foreach (rows[i])
		begin
			send(rows[i], 4'h1, 4'h3, 4'h4, 1'b0);
			$display("table case %0d done", i);
		end
		// sticky flag: read, clear, survives other arithmetic
		r = '{4'h9, 32'h0, 32'h0, 64'h0, 12'h0, 64'h08000000};
		send(r, 4'h1, 4'h3, 4'h4, 1'b0);
		r.op = 4'h8;
		send(r, 4'h1, 4'h3, 4'h4, 1'b0);
		r.op = 4'h9;
		r.res = 64'h0;
		send(r, 4'h1, 4'h3, 4'h4, 1'b0);
		send(rows[14], 4'h1, 4'h3, 4'h4, 1'b0);
		send(rows[9], 4'h1, 4'h3, 4'h4, 1'b0);
		send(r, 4'h1, 4'h3, 4'h4, 1'b0);
		send(rows[15], 4'h1, 4'h3, 4'h4, 1'b0);
		send(rows[0], 4'h1, 4'h3, 4'h4, 1'b0);
		send(rows[10], 4'h1, 4'h3, 4'h4, 1'b0);
		r.res = 64'h08000000;
		send(r, 4'h1, 4'h3, 4'h4, 1'b0);
		$display("sticky flag test done");
		// refused commands, then a legal one to show recovery
		r = '{4'h0, 32'h3, 32'h5, 64'h0, 12'h0, 64'hF};
		send(r, 4'h1, 4'h3, 4'h3, 1'b1);
		send(r, 4'hD, 4'h3, 4'h4, 1'b1);
		send(r, 4'h1, 4'hF, 4'h4, 1'b1);
		r.op = 4'h6;
		send(r, 4'h1, 4'h3, 4'h4, 1'b1);
		r.ctl = 12'h840;
		send(r, 4'h1, 4'h3, 4'h4, 1'b1);
		r.op = 4'h7;
		r.ctl = 12'h800;
		send(r, 4'h1, 4'h3, 4'h4, 1'b1);
		r.ctl = 12'h220;
		send(r, 4'h1, 4'h3, 4'h4, 1'b1);
		r.op = 4'h0;
		r.ctl = 12'h0;
		send(r, 4'h1, 4'h3, 4'h4, 1'b0);
		$display("refusal test done");
		// reset lands in the middle of a divide
		cmd_op = lmds_pkg::LMDS_DIVU;
		cmd_valid = 1'b1;
		repeat (10) @(posedge ref_clk);
		#SKEW;
		rst = 1'b1;
		cmd_valid = 1'b0;
		repeat (5) @(posedge ref_clk);
		#SKEW;
		check("cmd_ready", cmd_ready, 1'b1);
		check("out_valid", out_valid, 1'b0);
		rst = 1'b0;
		@(posedge ref_clk);
		#SKEW;
		r.op = 4'h9;
		r.res = 64'h0;
		send(r, 4'h1, 4'h3, 4'h4, 1'b0);
		$display("mid-run reset test done");
		finish_test();
	end
endmodule
